/* File: core/rcd_pkg.sv */
// Purpose: shared constants and field layouts of the reset configuration decoder
// Assumes: APB with 32-bit data; register byte address is four times the register index
// Notes:   configuration bytes are 8 bits wide and sit in the low byte lane
package rcd_pkg;

  // register indices; byte address is four times the index
  localparam logic [31:0] RCD_CFG_LOW_IDX  = 32'h0030_0002;
  localparam logic [31:0] RCD_CFG_HIGH_IDX = 32'h0030_0003;
  localparam logic [31:0] RCD_CTRL_IDX     = 32'h0030_0010;
  localparam logic [31:0] RCD_UNLOCK_IDX   = 32'h0030_0011;
  localparam logic [31:0] RCD_LOCK_IDX     = 32'h0030_0012;
  localparam logic [31:0] RCD_STATUS_IDX   = 32'h0030_0013;

  localparam logic [31:0] RCD_CFG_LOW_ADDR  = RCD_CFG_LOW_IDX << 2;
  localparam logic [31:0] RCD_CFG_HIGH_ADDR = RCD_CFG_HIGH_IDX << 2;
  localparam logic [31:0] RCD_CTRL_ADDR     = RCD_CTRL_IDX << 2;
  localparam logic [31:0] RCD_UNLOCK_ADDR   = RCD_UNLOCK_IDX << 2;
  localparam logic [31:0] RCD_LOCK_ADDR     = RCD_LOCK_IDX << 2;
  localparam logic [31:0] RCD_STATUS_ADDR   = RCD_STATUS_IDX << 2;

  // blank device: every implemented bit erased to one
  localparam logic [7:0] RCD_BLANK_BYTE = 8'hff;
  // unimplemented bit 6 of the high byte, read as one
  localparam int unsigned RCD_HIGH_UNIMP_BIT = 6;
  localparam logic [7:0]  RCD_HIGH_UNIMP_MASK = 8'h40;

  // unlock sequence bytes
  localparam logic [7:0] RCD_UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] RCD_UNLOCK_KEY2 = 8'haa;

  // control register bit positions
  localparam int unsigned RCD_CTRL_SW_BO_BIT = 0;
  localparam int unsigned RCD_CTRL_ZC_EN_BIT = 1;
  localparam logic [1:0] RCD_CTRL_RESET = 2'h0;

  // lock register bit positions
  localparam int unsigned RCD_LOCK_VEC_BIT   = 0;
  localparam int unsigned RCD_LOCK_REMAP_BIT = 1;

  // brown-out enable field encodings
  localparam logic [1:0] RCD_BO_ALWAYS = 2'h3;
  localparam logic [1:0] RCD_BO_AWAKE  = 2'h2;
  localparam logic [1:0] RCD_BO_SOFT   = 2'h1;
  localparam logic [1:0] RCD_BO_OFF    = 2'h0;

  // power-up delay select encodings and delays
  localparam logic [1:0] RCD_PUD_OFF  = 2'h3;
  localparam logic [1:0] RCD_PUD_64MS = 2'h2;
  localparam logic [1:0] RCD_PUD_16MS = 2'h1;
  localparam logic [1:0] RCD_PUD_1MS  = 2'h0;
  localparam int unsigned RCD_PUD_64_MS = 64;
  localparam int unsigned RCD_PUD_16_MS = 16;
  localparam int unsigned RCD_PUD_1_MS  = 1;
  // delays counted in low-frequency oscillator cycles
  localparam logic [11:0] RCD_PUD_64_CYC = 12'd2048;
  localparam logic [11:0] RCD_PUD_16_CYC = 12'd512;
  localparam logic [11:0] RCD_PUD_1_CYC  = 12'd32;

  typedef struct packed {
    logic [1:0] brownout_enable_field;
    logic       low_power_brownout_enable;
    logic       vector_table_one_way;
    logic       multi_vector_enable;
    logic [1:0] power_up_delay_select;
    logic       master_clear_pin_enable;
  } rcd_cfg_low_t;

  typedef struct packed {
    logic       extended_instruction_enable;
    logic       unimplemented;
    logic       debugger_enable_n;
    logic       stack_fault_reset_enable;
    logic       pin_remap_one_way;
    logic       zero_cross_disable;
    logic [1:0] brownout_threshold_select;
  } rcd_cfg_high_t;

  typedef enum logic [1:0] {
    RCD_ST_LOAD,
    RCD_ST_WAIT,
    RCD_ST_RUN
  } rcd_state_t;

endpackage : rcd_pkg

/* File: core/rcd_lock_ctl.sv */
// Purpose: one lock flag guarded by an unlock sequence, optionally one-way
// Assumes: wr_en is a one-cycle pulse already qualified by the unlock sequence
// Notes:   the flag clears on reset, so the register set starts unlocked
`timescale 1ns/10ps
`default_nettype none
module rcd_lock_ctl
  import rcd_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic one_way,
  input  wire logic wr_en,
  input  wire logic wr_value,
  // state
  output logic      locked
);

  logic locked_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      locked_q <= 1'b0;
    end
    else if (wr_en)
    begin
      // once set in one-way mode the flag can no longer be cleared
      if (!(one_way && locked_q))
      begin
        locked_q <= wr_value;
      end
    end
  end

  assign locked = locked_q;

endmodule // rcd_lock_ctl
`default_nettype wire

/* File: core/rcd_top.sv */
// Purpose: decodes two configuration bytes into reset, interrupt, debug and pin controls
// Assumes: por_n clears the nonvolatile image to blank; presetn is a device reset
// Notes:   APB answers one wait state after the setup cycle; unmapped addresses give pslverr
`timescale 1ns/10ps
`default_nettype none
module rcd_top
  import rcd_pkg::*;
#(
  parameter int unsigned PUD_CNT_W = 12
)
(
  // clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // system inputs
  input  wire logic        lf_osc_clk,
  input  wire logic        shared_clear_pin,
  input  wire logic        low_voltage_programming,
  input  wire logic        sleep_mode,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  // reset and power controls
  output logic             core_reset_n,
  output logic             brownout_reset_en,
  output logic             low_power_brownout_en,
  output logic [1:0]       brownout_threshold_select,
  output logic             stack_reset_req,
  // core and interrupt controls
  output logic             vector_table_en,
  output logic             extended_instruction_en,
  output logic             debugger_en,
  output logic             vector_table_locked,
  output logic             pin_remap_locked,
  // pin controls
  output logic             master_clear_en,
  output logic             master_clear_n,
  output logic             shared_pin_in,
  output logic             zero_cross_en
);

  // refused at elaboration: the longest delay needs twelve counter bits
  if (PUD_CNT_W < 12)
  begin : g_width_check
    $error("PUD_CNT_W too narrow for the longest power-up delay");
  end

  function automatic logic [PUD_CNT_W-1:0] pud_limit(input logic [1:0] sel);
    logic [PUD_CNT_W-1:0] lim;
    lim = '0;
    case (sel)
      RCD_PUD_64MS: lim = PUD_CNT_W'(RCD_PUD_64_CYC);
      RCD_PUD_16MS: lim = PUD_CNT_W'(RCD_PUD_16_CYC);
      RCD_PUD_1MS:  lim = PUD_CNT_W'(RCD_PUD_1_CYC);
      default:      lim = '0;
    endcase
    return lim;
  endfunction

  // nonvolatile image and latched copy
  rcd_cfg_low_t  nv_low_q;
  rcd_cfg_high_t nv_high_q;
  rcd_cfg_low_t  cfg_low_q;
  rcd_cfg_high_t cfg_high_q;

  // reset sequencer
  rcd_state_t            state_q;
  logic [PUD_CNT_W-1:0]  pud_cnt_q;
  logic [PUD_CNT_W-1:0]  pud_lim_q;
  logic                  running;

  // synchronisers
  logic lf_meta_q;
  logic lf_sync_q;
  logic lf_prev_q;
  logic lf_rise;
  logic pin_meta_q;
  logic pin_sync_q;

  // software state
  logic       sw_bo_q;
  logic       zc_soft_q;
  logic [1:0] unlock_step_q;
  logic       unlock_armed;
  logic       vec_locked;
  logic       remap_locked;

  // apb
  logic        req_setup;
  logic        req_commit;
  logic        wr_commit;
  logic        byte0_wr;
  logic        hit_cfg_low;
  logic        hit_cfg_high;
  logic        hit_ctrl;
  logic        hit_unlock;
  logic        hit_lock;
  logic        hit_status;
  logic        hit_any;
  logic [31:0] rd_mux;
  logic        lock_wr;

  // pin inputs cross into pclk through two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lf_meta_q  <= 1'b0;
      lf_sync_q  <= 1'b0;
      lf_prev_q  <= 1'b0;
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end
    else
    begin
      lf_meta_q  <= lf_osc_clk;
      lf_sync_q  <= lf_meta_q;
      lf_prev_q  <= lf_sync_q;
      pin_meta_q <= shared_clear_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign lf_rise = lf_sync_q && !lf_prev_q;

  // address decode
  always_comb
  begin
    hit_cfg_low  = 1'b0;
    hit_cfg_high = 1'b0;
    hit_ctrl     = 1'b0;
    hit_unlock   = 1'b0;
    hit_lock     = 1'b0;
    hit_status   = 1'b0;
    if (paddr == RCD_CFG_LOW_ADDR)
    begin
      hit_cfg_low = 1'b1;
    end
    else if (paddr == RCD_CFG_HIGH_ADDR)
    begin
      hit_cfg_high = 1'b1;
    end
    else if (paddr == RCD_CTRL_ADDR)
    begin
      hit_ctrl = 1'b1;
    end
    else if (paddr == RCD_UNLOCK_ADDR)
    begin
      hit_unlock = 1'b1;
    end
    else if (paddr == RCD_LOCK_ADDR)
    begin
      hit_lock = 1'b1;
    end
    else if (paddr == RCD_STATUS_ADDR)
    begin
      hit_status = 1'b1;
    end
  end

  assign hit_any    = hit_cfg_low | hit_cfg_high | hit_ctrl | hit_unlock | hit_lock | hit_status;
  assign req_setup  = psel && penable && !pready;
  assign req_commit = psel && penable && pready;
  // writes land only on the edge where the master sees pready
  assign wr_commit  = req_commit && pwrite && !pslverr;
  assign byte0_wr   = wr_commit && pstrb[0];

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg_low)
    begin
      rd_mux[7:0] = nv_low_q;
    end
    else if (hit_cfg_high)
    begin
      rd_mux[7:0] = nv_high_q | RCD_HIGH_UNIMP_MASK;
    end
    else if (hit_ctrl)
    begin
      rd_mux[RCD_CTRL_SW_BO_BIT] = sw_bo_q;
      rd_mux[RCD_CTRL_ZC_EN_BIT] = zc_soft_q;
    end
    else if (hit_unlock)
    begin
      rd_mux[0] = unlock_armed;
    end
    else if (hit_lock)
    begin
      rd_mux[RCD_LOCK_VEC_BIT]   = vec_locked;
      rd_mux[RCD_LOCK_REMAP_BIT] = remap_locked;
    end
    else if (hit_status)
    begin
      rd_mux[1:0]  = state_q;
      rd_mux[15:4] = 12'(pud_cnt_q);
    end
  end

  // one wait state so every apb output comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (req_setup)
    begin
      pready  <= 1'b1;
      pslverr <= !hit_any;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // nonvolatile image survives device resets, only power-on blanks it
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      nv_low_q  <= RCD_BLANK_BYTE;
      nv_high_q <= RCD_BLANK_BYTE;
    end
    else if (byte0_wr && hit_cfg_low)
    begin
      nv_low_q <= pwdata[7:0];
    end
    else if (byte0_wr && hit_cfg_high)
    begin
      nv_high_q <= pwdata[7:0] | RCD_HIGH_UNIMP_MASK;
    end
  end

  // reset sequencer: load, power-up delay, run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= RCD_ST_LOAD;
      pud_cnt_q  <= '0;
      pud_lim_q  <= '0;
      cfg_low_q  <= RCD_BLANK_BYTE;
      cfg_high_q <= RCD_BLANK_BYTE;
    end
    else
    begin
      case (state_q)
        RCD_ST_LOAD:
        begin
          cfg_low_q  <= nv_low_q;
          cfg_high_q <= nv_high_q;
          pud_cnt_q  <= '0;
          pud_lim_q  <= pud_limit(nv_low_q.power_up_delay_select);
          if (nv_low_q.power_up_delay_select == RCD_PUD_OFF)
          begin
            state_q <= RCD_ST_RUN;
          end
          else
          begin
            state_q <= RCD_ST_WAIT;
          end
        end
        RCD_ST_WAIT:
        begin
          if (lf_rise)
          begin
            pud_cnt_q <= pud_cnt_q + PUD_CNT_W'(1);
            if (pud_cnt_q + PUD_CNT_W'(1) == pud_lim_q)
            begin
              state_q <= RCD_ST_RUN;
            end
          end
        end
        RCD_ST_RUN:
        begin
          state_q <= RCD_ST_RUN;
        end
        default:
        begin
          state_q <= RCD_ST_LOAD;
        end
      endcase
    end
  end

  assign running = (state_q == RCD_ST_RUN);

  // software control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_bo_q   <= RCD_CTRL_RESET[0];
      zc_soft_q <= RCD_CTRL_RESET[1];
    end
    else if (byte0_wr && hit_ctrl)
    begin
      sw_bo_q   <= pwdata[RCD_CTRL_SW_BO_BIT];
      zc_soft_q <= pwdata[RCD_CTRL_ZC_EN_BIT];
    end
  end

  // unlock sequence: key1 then key2 arms the next lock write only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unlock_step_q <= 2'h0;
    end
    else if (byte0_wr && hit_unlock)
    begin
      if (pwdata[7:0] == RCD_UNLOCK_KEY1)
      begin
        unlock_step_q <= 2'h1;
      end
      else if (pwdata[7:0] == RCD_UNLOCK_KEY2 && unlock_step_q == 2'h1)
      begin
        unlock_step_q <= 2'h2;
      end
      else
      begin
        unlock_step_q <= 2'h0;
      end
    end
    else if (wr_commit)
    begin
      // any other write that draws no pslverr spends or breaks the sequence
      unlock_step_q <= 2'h0;
    end
  end

  assign unlock_armed = (unlock_step_q == 2'h2);
  assign lock_wr      = byte0_wr && hit_lock && unlock_armed;

  rcd_lock_ctl u_vec_lock (
    .pclk     (pclk),
    .presetn  (presetn),
    .one_way  (cfg_low_q.vector_table_one_way),
    .wr_en    (lock_wr),
    .wr_value (pwdata[RCD_LOCK_VEC_BIT]),
    .locked   (vec_locked)
  );

  rcd_lock_ctl u_remap_lock (
    .pclk     (pclk),
    .presetn  (presetn),
    .one_way  (cfg_high_q.pin_remap_one_way),
    .wr_en    (lock_wr),
    .wr_value (pwdata[RCD_LOCK_REMAP_BIT]),
    .locked   (remap_locked)
  );

  // decoded controls follow the latched copy; users wait for core_reset_n
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_reset_n              <= 1'b0;
      brownout_reset_en         <= 1'b0;
      low_power_brownout_en     <= 1'b0;
      brownout_threshold_select <= 2'h0;
      vector_table_en           <= 1'b0;
      extended_instruction_en   <= 1'b0;
      debugger_en               <= 1'b0;
      vector_table_locked       <= 1'b0;
      pin_remap_locked          <= 1'b0;
      zero_cross_en             <= 1'b0;
    end
    else
    begin
      core_reset_n <= running;
      case (cfg_low_q.brownout_enable_field)
        RCD_BO_ALWAYS: brownout_reset_en <= 1'b1;
        RCD_BO_AWAKE:  brownout_reset_en <= !sleep_mode;
        RCD_BO_SOFT:   brownout_reset_en <= sw_bo_q;
        default:        brownout_reset_en <= 1'b0;
      endcase
      low_power_brownout_en     <= !cfg_low_q.low_power_brownout_enable;
      brownout_threshold_select <= cfg_high_q.brownout_threshold_select;
      vector_table_en           <= cfg_low_q.multi_vector_enable;
      extended_instruction_en   <= !cfg_high_q.extended_instruction_enable;
      debugger_en               <= !cfg_high_q.debugger_enable_n;
      vector_table_locked       <= vec_locked;
      pin_remap_locked          <= remap_locked;
      zero_cross_en <= !cfg_high_q.zero_cross_disable || zc_soft_q;
    end
  end

  // stack fault reset request, registered and held high for as long as a stack fault lasts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stack_reset_req <= 1'b0;
    end
    else
    begin
      stack_reset_req <= running && cfg_high_q.stack_fault_reset_enable
                         && (stack_overflow || stack_underflow);
    end
  end

  // shared pin: master clear or plain input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      master_clear_en <= 1'b1;
      master_clear_n  <= 1'b1;
      shared_pin_in   <= 1'b0;
    end
    else
    begin
      if (low_voltage_programming || cfg_low_q.master_clear_pin_enable)
      begin
        master_clear_en <= 1'b1;
        master_clear_n  <= pin_sync_q;
        shared_pin_in   <= 1'b0;
      end
      else
      begin
        master_clear_en <= 1'b0;
        master_clear_n  <= 1'b1;
        shared_pin_in   <= pin_sync_q;
      end
    end
  end

endmodule // rcd_top
`default_nettype wire

/* File: bench/rcd_top_props.sv */
// Purpose: port-level checks for the reset configuration decoder
// Assumes: bound to rcd_top and sees only its ports
// Notes:   outputs that depend on the latched image are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module rcd_top_props
  import rcd_pkg::*;
#(
  parameter int unsigned PUD_CNT_W = 12
)
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // system
  input wire logic        stack_overflow,
  input wire logic        stack_underflow,
  input wire logic        low_voltage_programming,
  // decoded controls
  input wire logic        core_reset_n,
  input wire logic        stack_reset_req,
  input wire logic        low_power_brownout_en,
  input wire logic        vector_table_en,
  input wire logic        extended_instruction_en,
  input wire logic        debugger_en,
  input wire logic        master_clear_en,
  input wire logic        master_clear_n,
  input wire logic        shared_pin_in
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    ##2 pready;
  endsequence

  apb_answer_time_a: assert property (setup_s |-> answer_s)
    else $error("apb answer not two cycles after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  stack_req_cause_a: assert property (
    stack_reset_req |-> $past(stack_overflow || stack_underflow))
    else $error("stack reset request without a stack fault");
  config_held_a: assert property (
    core_reset_n && $past(core_reset_n) |->
    $stable({low_power_brownout_en, vector_table_en, extended_instruction_en, debugger_en}))
    else $error("decoded control changed while running");
  lowv_forces_clear_a: assert property (low_voltage_programming |=> master_clear_en)
    else $error("low-voltage programming did not force master clear");
  pin_input_off_a: assert property (
    master_clear_en && $past(master_clear_en) |-> !shared_pin_in)
    else $error("port input live while pin is master clear");
  clear_idle_a: assert property (
    !master_clear_en && $past(!master_clear_en) |-> master_clear_n)
    else $error("master clear asserted while pin is a port input");
endmodule // rcd_top_props
`default_nettype wire

/* File: bench/rcd_top_tb.sv */
// Purpose: self-checking bench for the reset configuration decoder
// Assumes: lf oscillator at a quarter of pclk to keep power-up delays short
// Notes:   each scenario after the blank check rewrites the image and restarts through presetn
`timescale 1ns/10ps
`default_nettype none
module rcd_top_tb;
  import rcd_pkg::*;
  logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic        lf_osc_clk, shared_clear_pin, low_voltage_programming, sleep_mode;
  logic        stack_overflow, stack_underflow, core_reset_n, brownout_reset_en;
  logic        low_power_brownout_en, stack_reset_req, vector_table_en;
  logic        extended_instruction_en, debugger_en, vector_table_locked;
  logic        pin_remap_locked, master_clear_en, master_clear_n, shared_pin_in;
  logic        zero_cross_en;
  logic [1:0]  brownout_threshold_select;
  int          bad_count, comparisons, cyc;

  rcd_top rcd_top_inst (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lf_osc_clk(lf_osc_clk),
    .shared_clear_pin(shared_clear_pin), .low_voltage_programming(low_voltage_programming),
    .sleep_mode(sleep_mode), .stack_overflow(stack_overflow),
    .stack_underflow(stack_underflow), .core_reset_n(core_reset_n),
    .brownout_reset_en(brownout_reset_en), .low_power_brownout_en(low_power_brownout_en),
    .brownout_threshold_select(brownout_threshold_select),
    .stack_reset_req(stack_reset_req), .vector_table_en(vector_table_en),
    .extended_instruction_en(extended_instruction_en), .debugger_en(debugger_en),
    .vector_table_locked(vector_table_locked), .pin_remap_locked(pin_remap_locked),
    .master_clear_en(master_clear_en), .master_clear_n(master_clear_n),
    .shared_pin_in(shared_pin_in), .zero_cross_en(zero_cross_en)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // free-running oscillator at a quarter of pclk, toggling on pclk falling edges
  initial
  begin
    lf_osc_clk = 1'b0;
    forever #20 lf_osc_clk = ~lf_osc_clk;
  end

  task automatic test_done();
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  function automatic logic [31:0] dec();
    return {23'h0, brownout_reset_en, low_power_brownout_en, vector_table_en,
            extended_instruction_en, debugger_en, master_clear_en, zero_cross_en,
            brownout_threshold_select};
  endfunction

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // answer comes on the second access edge
    chk1(k == 2, 1'b1);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk32(r, x);
    chk1(e, xe);
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 9000)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
  endtask

  task automatic boot(input logic [7:0] lo, input logic [7:0] hi, output int n);
    wr(RCD_CFG_LOW_ADDR, lo);
    wr(RCD_CFG_HIGH_ADDR, hi);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    wait_run(n);
  endtask

  task automatic lock_wr(input logic [7:0] v);
    wr(RCD_UNLOCK_ADDR, RCD_UNLOCK_KEY1);
    wr(RCD_UNLOCK_ADDR, RCD_UNLOCK_KEY2);
    wr(RCD_LOCK_ADDR, v);
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_blank();
    int n;
    wait_run(n);
    chk1(n inside {[3:4]}, 1'b1);
    chk32(dec(), {23'h0, 7'b1010010, 2'b11});
    rd_chk(RCD_CFG_LOW_ADDR, 32'hff, 1'b0);
    rd_chk(RCD_CFG_HIGH_ADDR, 32'hff, 1'b0);
    wr(RCD_CFG_HIGH_ADDR, 8'h00);
    rd_chk(RCD_CFG_HIGH_ADDR, 32'h40, 1'b0);
    rd_chk(32'h0000_0100, 32'h0, 1'b1);
  endtask

  task automatic t_decode();
    logic [1:0] f;
    logic       p;
    logic [7:0] lo;
    int         n;
    int         nc;
    for (int i = 0; i < 4; i++)
    begin
      f = i[1:0];
      p = i[0];
      lo = {f, p, 1'b1, p, f, p};
      boot(lo, {p, 1'b1, p, 1'b0, 1'b1, p, f}, n);
      nc = (f == 2'h0) ? 32 : (f == 2'h1) ? 512 : 2048;
      if (f == 2'h3)
        chk1(n inside {[3:4]}, 1'b1);
      else
        chk1(n >= 4 * nc - 4 && n <= 4 * nc + 12, 1'b1);
      chk32(dec(), {23'h0, f[1], !p, p, !p, !p, p, !p, f});
      sleep_mode <= 1'b1;
      wr(RCD_CTRL_ADDR, 8'h03);
      repeat (2) @(posedge pclk);
      chk1(brownout_reset_en, f[0]);
      chk1(zero_cross_en, 1'b1);
      wr(RCD_CFG_LOW_ADDR, ~lo);
      repeat (2) @(posedge pclk);
      chk1(vector_table_en, p);
      sleep_mode <= 1'b0;
    end
  endtask

  task automatic t_pin();
    int n;
    boot(8'hfe, 8'hff, n);
    shared_clear_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    chk32({29'h0, master_clear_en, shared_pin_in, master_clear_n}, 32'h3);
    shared_clear_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    chk32({29'h0, master_clear_en, shared_pin_in, master_clear_n}, 32'h1);
    low_voltage_programming <= 1'b1;
    repeat (4) @(posedge pclk);
    chk32({29'h0, master_clear_en, shared_pin_in, master_clear_n}, 32'h4);
    low_voltage_programming <= 1'b0;
    shared_clear_pin <= 1'b1;
  endtask

  task automatic t_stack();
    int n;
    boot(8'hff, 8'hff, n);
    stack_overflow <= 1'b1;
    repeat (2) @(posedge pclk);
    chk1(stack_reset_req, 1'b1);
    stack_overflow  <= 1'b0;
    stack_underflow <= 1'b1;
    repeat (2) @(posedge pclk);
    chk1(stack_reset_req, 1'b1);
    stack_underflow <= 1'b0;
    boot(8'hff, 8'hef, n);
    stack_overflow <= 1'b1;
    repeat (2) @(posedge pclk);
    chk1(stack_reset_req, 1'b0);
    stack_overflow <= 1'b0;
  endtask

  task automatic t_lock();
    int n;
    boot(8'hff, 8'hff, n);
    wr(RCD_LOCK_ADDR, 8'h03);
    repeat (3) @(posedge pclk);
    chk32({30'h0, vector_table_locked, pin_remap_locked}, 32'h0);
    lock_wr(8'h03);
    chk32({30'h0, vector_table_locked, pin_remap_locked}, 32'h3);
    lock_wr(8'h00);
    chk32({30'h0, vector_table_locked, pin_remap_locked}, 32'h3);
    boot(8'hef, 8'hf7, n);
    lock_wr(8'h03);
    lock_wr(8'h00);
    chk32({30'h0, vector_table_locked, pin_remap_locked}, 32'h0);
    lock_wr(8'h01);
    chk32({30'h0, vector_table_locked, pin_remap_locked}, 32'h2);
  endtask

  initial
  begin
    presetn = 1'b0;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    shared_clear_pin = 1'b1;
    low_voltage_programming = 1'b0;
    sleep_mode = 1'b0;
    stack_overflow = 1'b0;
    stack_underflow = 1'b0;
    bad_count = 0;
    comparisons = 0;
    cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    t_blank();
    t_decode();
    t_pin();
    t_stack();
    t_lock();
    test_done();
  end
endmodule // rcd_top_tb

bind rcd_top rcd_top_props #(.PUD_CNT_W(PUD_CNT_W)) rcd_top_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .stack_overflow(stack_overflow),
  .stack_underflow(stack_underflow), .low_voltage_programming(low_voltage_programming),
  .core_reset_n(core_reset_n), .stack_reset_req(stack_reset_req),
  .low_power_brownout_en(low_power_brownout_en), .vector_table_en(vector_table_en),
  .extended_instruction_en(extended_instruction_en), .debugger_en(debugger_en),
  .master_clear_en(master_clear_en), .master_clear_n(master_clear_n),
  .shared_pin_in(shared_pin_in)
);
`default_nettype wire
